/* hw/pmx_pkg.sv */
// Purpose: Shared constants for the port A low pin mux and port B direction block
// Assumes: 16-bit register port, one clock
// Notes:   Register offsets are chosen locally; field positions follow the select layout
package pmx_pkg;
  // Register port geometry
  localparam int unsigned    ADDR_W        = 4;
  localparam int unsigned    DATA_W        = 16;
  localparam logic [3:0]     OFF_FUNC_SEL  = 4'h0;   // Lower port function select
  localparam logic [3:0]     OFF_PIN_DIR   = 4'h2;   // Second port direction
  // Reset images
  localparam logic [15:0]    FUNC_SEL_RST  = 16'hff95;
  localparam logic [15:0]    PIN_DIR_RST   = 16'h0000;
  localparam logic [15:0]    RSVD_ONES     = 16'haa00; // Bits 15, 13, 11, 9
  // Single-bit role fields
  localparam int unsigned    B_PIN7        = 14;
  localparam int unsigned    B_PIN6        = 12;
  localparam int unsigned    B_PIN5        = 10;
  localparam int unsigned    B_PIN4        = 8;
  // Two-bit role fields, low bit position
  localparam int unsigned    F_PIN3        = 6;
  localparam int unsigned    F_PIN2        = 4;
  localparam int unsigned    F_PIN1        = 2;
  localparam int unsigned    F_PIN0        = 0;
  // Two-bit role codes
  localparam logic [1:0]     ROLE_IO       = 2'h0;
  localparam logic [1:0]     ROLE_CS       = 2'h1;
  localparam logic [1:0]     ROLE_ALT      = 2'h2;  // Wait, timer or row strobe
  localparam logic [1:0]     ROLE_RSVD     = 2'h3;
  // Second port pin role codes supplied by the port B control logic
  typedef enum logic [1:0] {
    PMX_B_IO     = 2'b00,
    PMX_B_TIMER  = 2'b01,
    PMX_B_SCLK   = 2'b10,
    PMX_B_OTHER  = 2'b11
  } pmx_brole_t;
endpackage : pmx_pkg

/* hw/pmx_port_mux.sv */
// Purpose: Lower port A pin role mux and port B pin direction register
// Assumes: Power-on reset is i_rst_n; manual reset, standby and sleep never reach it
// Notes:   Outputs are registered, so pin roles follow register writes one cycle later
//
// Functional notes
// - Odd upper reserved bits read one always
// - Bit 14: pin7 I/O or bus acknowledge
// - Bit 12: pin6 I/O or read strobe
// - Bit 10: pin5 I/O or upper write strobe
// - Bit 8: pin4 I/O or lower write strobe
// - Bits 7:6 pin3: I/O, select 7, wait
// - Pin3 pull-up only as wait and requested
// - Bits 5:4 pin2: I/O, select 6, timer B
// - Bits 3:2 pin1: I/O, select 5, row strobe
// - Bits 1:0 pin0: I/O, select 4, timer A
// - Direction bit one drives output, zero input
// - Direction ignored for other second-port roles
// - Direction register clears on power-on only
// - Function register loads pattern on power-on only
module pmx_port_mux (
  input  wire logic                          i_core_clk,    // Core clock, 40 MHz
  input  wire logic                          i_rst_n,       // Power-on reset, active low
  input  wire logic [pmx_pkg::ADDR_W-1:0]    i_addr,        // Register address
  input  wire logic [pmx_pkg::DATA_W-1:0]    i_wdata,       // Write data
  input  wire logic                          i_wr,          // Write strobe
  input  wire logic                          i_rd,          // Read strobe
  input  wire logic                          i_wait_pull_req, // Bus controller asks pull-up
  input  wire logic [15:0]                   i_b_role0,     // Port B role code, low bits
  input  wire logic [15:0]                   i_b_role1,     // Port B role code, high bits
  output logic      [pmx_pkg::DATA_W-1:0]    o_rdata,       // Read data, cycle after read
  output logic      [7:0]                    o_pin_alt,     // Pin uses a peripheral role
  output logic      [7:0]                    o_pin_alt_out, // Peripheral role drives pin
  output logic      [1:0]                    o_pin0_role,   // Pin0 decoded role code
  output logic      [1:0]                    o_pin1_role,   // Pin1 decoded role code
  output logic      [1:0]                    o_pin2_role,   // Pin2 decoded role code
  output logic      [1:0]                    o_pin3_role,   // Pin3 decoded role code
  output logic      [7:0]                    o_pin_rsvd,    // Pin holds a reserved code
  output logic                               o_pin3_pullup, // Pin3 pull-up enable
  output logic      [15:0]                   o_b_out_en     // Port B pin drives output
);
  import pmx_pkg::*;

  // Whole module state in one record
  typedef struct packed {
    logic [15:0] func_reg;      // Stored function select, reserved bits held high
    logic [15:0] dir_reg;       // Port B direction
    logic [15:0] rdata_reg;     // Read return
    logic [7:0]  alt_reg;       // Peripheral role per pin
    logic [7:0]  alt_out_reg;   // Peripheral role is an output
    logic [7:0]  rsvd_reg;      // Reserved code flags
    logic [7:0]  roles_reg;     // Four two-bit role codes
    logic        pull_reg;      // Pin3 pull-up
    logic [15:0] b_oe_reg;      // Port B output enables
  } pmx_state_t;

  pmx_state_t st_reg;   // Registered state
  pmx_state_t st_next;  // Next state

  // Function register as seen by software: reserved bits forced high
  function automatic logic [15:0] func_view(input logic [15:0] f);
    func_view = f | RSVD_ONES;
  endfunction

  // Role field extraction, used for all four two-bit pins
  function automatic logic [1:0] field2(input logic [15:0] f, input int unsigned lo);
    field2 = f[lo +: 2];
  endfunction

  logic [1:0] r0, r1, r2, r3;   // Current two-bit role codes
  logic [1:0] brole [16];       // Port B role per pin

  // Decode current role fields
  always_comb begin
    r0 = field2(st_reg.func_reg, F_PIN0);
    r1 = field2(st_reg.func_reg, F_PIN1);
    r2 = field2(st_reg.func_reg, F_PIN2);
    r3 = field2(st_reg.func_reg, F_PIN3);
  end

  // Gather port B role codes per pin
  for (genvar g = 0; g < 16; g++) begin : g_brole
    assign brole[g] = {i_b_role1[g], i_b_role0[g]};
  end

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    // Register writes; a write to an unmapped address is dropped
    if (i_wr) begin
      case (i_addr)
        OFF_FUNC_SEL: st_next.func_reg = func_view(i_wdata);
        OFF_PIN_DIR:  st_next.dir_reg  = i_wdata;
        default:      st_next.func_reg = st_reg.func_reg;
      endcase
    end
    // Read data held only for the cycle after the strobe
    st_next.rdata_reg = '0;
    if (i_rd) begin
      case (i_addr)
        OFF_FUNC_SEL: st_next.rdata_reg = func_view(st_reg.func_reg);
        OFF_PIN_DIR:  st_next.rdata_reg = st_reg.dir_reg;
        default:      st_next.rdata_reg = '0; // Unmapped reads as zero
      endcase
    end
    // Single-bit pins 7..4: all peripheral roles here are outputs
    st_next.alt_reg[7]     = st_reg.func_reg[B_PIN7];
    st_next.alt_reg[6]     = st_reg.func_reg[B_PIN6];
    st_next.alt_reg[5]     = st_reg.func_reg[B_PIN5];
    st_next.alt_reg[4]     = st_reg.func_reg[B_PIN4];
    st_next.alt_out_reg[7:4] = st_next.alt_reg[7:4];
    st_next.rsvd_reg[7:4]  = 4'h0;
    // Pin3: select 7 drives, wait is an input
    st_next.alt_reg[3]     = (r3 == ROLE_CS) || (r3 == ROLE_ALT);
    st_next.alt_out_reg[3] = (r3 == ROLE_CS);
    st_next.rsvd_reg[3]    = (r3 == ROLE_RSVD);
    // Pull-up only while serving as wait input; I/O and select never pull
    st_next.pull_reg       = (r3 == ROLE_ALT) && i_wait_pull_req;
    // Pin2: select 6 drives; timer direction is owned by the timer
    st_next.alt_reg[2]     = (r2 == ROLE_CS) || (r2 == ROLE_ALT);
    st_next.alt_out_reg[2] = (r2 == ROLE_CS);
    st_next.rsvd_reg[2]    = (r2 == ROLE_RSVD);
    // Pin1: select 5 and row strobe both drive
    st_next.alt_reg[1]     = (r1 == ROLE_CS) || (r1 == ROLE_ALT);
    st_next.alt_out_reg[1] = st_next.alt_reg[1];
    st_next.rsvd_reg[1]    = (r1 == ROLE_RSVD);
    // Pin0: select 4 drives; timer direction is owned by the timer
    st_next.alt_reg[0]     = (r0 == ROLE_CS) || (r0 == ROLE_ALT);
    st_next.alt_out_reg[0] = (r0 == ROLE_CS);
    st_next.rsvd_reg[0]    = (r0 == ROLE_RSVD);
    // Reserved codes: decoded role forced to I/O with no drive, avoiding contention
    st_next.roles_reg[1:0] = (r0 == ROLE_RSVD) ? ROLE_IO : r0;
    st_next.roles_reg[3:2] = (r1 == ROLE_RSVD) ? ROLE_IO : r1;
    st_next.roles_reg[5:4] = (r2 == ROLE_RSVD) ? ROLE_IO : r2;
    st_next.roles_reg[7:6] = (r3 == ROLE_RSVD) ? ROLE_IO : r3;
    // Port B enables: direction bit counts only for I/O, timer and serial clock
    for (int i = 0; i < 16; i++) begin
      case (pmx_brole_t'(brole[i]))
        PMX_B_IO, PMX_B_TIMER, PMX_B_SCLK: st_next.b_oe_reg[i] = st_reg.dir_reg[i];
        PMX_B_OTHER: st_next.b_oe_reg[i] = 1'b0;
        default:     st_next.b_oe_reg[i] = 1'b0;
      endcase
    end
  end

  // State register; only power-on reset touches the two software registers
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg             <= '0;
      st_reg.func_reg    <= FUNC_SEL_RST;
      st_reg.dir_reg     <= PIN_DIR_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign o_rdata       = st_reg.rdata_reg;
  assign o_pin_alt     = st_reg.alt_reg;
  assign o_pin_alt_out = st_reg.alt_out_reg;
  assign o_pin0_role   = st_reg.roles_reg[1:0];
  assign o_pin1_role   = st_reg.roles_reg[3:2];
  assign o_pin2_role   = st_reg.roles_reg[5:4];
  assign o_pin3_role   = st_reg.roles_reg[7:6];
  assign o_pin_rsvd    = st_reg.rsvd_reg;
  assign o_pin3_pullup = st_reg.pull_reg;
  assign o_b_out_en    = st_reg.b_oe_reg;
endmodule : pmx_port_mux

/* test/pmx_periph_model.sv */
// Purpose: Bus controller and port B control stand-in
// Assumes: Role codes {role1,role0} per pin
// Notes:   Mixed pattern gives pin i the code i mod 4
module pmx_periph_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_pull_want,         // Pin3 pull-up wanted
  input  wire logic        i_mix,               // Mixed port B roles
  output logic             o_wait_pull_req = 1'b0,
  output logic [15:0]      o_b_role0 = 16'h0000,
  output logic [15:0]      o_b_role1 = 16'h0000
);
  timeunit 1ns;
  timeprecision 100ps;
  // Levels change on an edge only, like real control registers
  always_ff @(posedge i_core_clk) begin
    o_wait_pull_req <= i_pull_want;
    o_b_role0       <= i_mix ? 16'haaaa : 16'h0000;
    o_b_role1       <= i_mix ? 16'hcccc : 16'h0000;
  end
endmodule // pmx_periph_model

/* test/pmx_port_mux_assertions.sv */
// Purpose: Port-level checks for the pin mux block
// Assumes: One clock, outputs registered
// Notes:   Sees only the top module ports
module pmx_chk (
  input wire logic        i_core_clk, i_rst_n, i_wr, i_rd, i_wait_pull_req, o_pin3_pullup,
  input wire logic [3:0]  i_addr,
  input wire logic [15:0] i_wdata, i_b_role0, i_b_role1, o_rdata, o_b_out_en,
  input wire logic [7:0]  o_pin_alt, o_pin_alt_out, o_pin_rsvd,
  input wire logic [1:0]  o_pin0_role, o_pin1_role, o_pin2_role, o_pin3_role
);
  timeunit 1ns;
  timeprecision 100ps;
  // One domain, so clock and reset are given once
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  property p_rsvd; $past(i_rd && i_addr == 4'h0) |-> (o_rdata & 16'haa00) == 16'haa00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read low");
  property p_up; o_pin_alt[7:4] == o_pin_alt_out[7:4] && o_pin_rsvd[7:4] == 4'h0; endproperty
  a_up: assert property (p_up) else $error("upper pin role bad");
  // A lone write shows on the upper pins two edges later
  property p_wr; (i_wr && i_addr == 4'h0) ##1 !i_wr |=> o_pin_alt[7:4] ==
    {$past(i_wdata[14], 2), $past(i_wdata[12], 2), $past(i_wdata[10], 2), $past(i_wdata[8], 2)};
  endproperty
  a_wr: assert property (p_wr) else $error("write not applied");
  property p_pull; o_pin3_pullup |-> o_pin3_role == 2'h2 && $past(i_wait_pull_req); endproperty
  a_pull: assert property (p_pull) else $error("pull-up outside wait role");
  property p_wait; o_pin3_role == 2'h2 |-> o_pin_alt[3] && !o_pin_alt_out[3]; endproperty
  a_wait: assert property (p_wait) else $error("wait pin driven");
  property p_tmr; (o_pin0_role != 2'h2 || !o_pin_alt_out[0]) && (o_pin2_role != 2'h2 || !o_pin_alt_out[2]); endproperty
  a_tmr: assert property (p_tmr) else $error("timer pin forced out");
  property p_ras; o_pin1_role == 2'h2 |-> o_pin_alt_out[1]; endproperty
  a_ras: assert property (p_ras) else $error("row strobe not driven");
  property p_rsv; (o_pin_rsvd[3:0] & (o_pin_alt[3:0] | o_pin_alt_out[3:0])) == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code drives");
  property p_dir; $stable(i_b_role0) && $stable(i_b_role1) |-> (o_b_out_en & i_b_role0 & i_b_role1) == 16'h0; endproperty
  a_dir: assert property (p_dir) else $error("direction not ignored");
endmodule // pmx_chk

/* test/pmx_port_mux_bench.sv */
// Purpose: Register-driven test of the pin mux block
// Assumes: Read data stands in the cycle after the strobe
// Notes:   Role outputs settle one edge after a write lands
module pmx_port_mux_bench;
  timeunit 1ns;
  timeprecision 100ps;  // Half period of 12.5 ns must not round
  import pmx_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, pull_want = 0, mix = 0, pull, pullq;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, out_en, role0, role1;
  logic [7:0]  alt, aout, rsvd;
  logic [1:0]  r0, r1, r2, r3, c;
  int bad_count = 0, n_tests = 0;
  always #12.5 clk = ~clk;
  pmx_port_mux pmx_port_mux_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_wait_pull_req(pullq), .i_b_role0(role0),
    .i_b_role1(role1), .o_rdata(rdata), .o_pin_alt(alt), .o_pin_alt_out(aout),
    .o_pin0_role(r0), .o_pin1_role(r1), .o_pin2_role(r2), .o_pin3_role(r3),
    .o_pin_rsvd(rsvd), .o_pin3_pullup(pull), .o_b_out_en(out_en));
  pmx_periph_model pmx_periph_model_i (.i_core_clk(clk), .i_pull_want(pull_want),
    .i_mix(mix), .o_wait_pull_req(pullq), .o_b_role0(role0), .o_b_role1(role1));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;  // Look at outputs once the launching edge has settled
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic finish_test();
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Reset image, every role code with both pull-up requests, then direction
  initial begin
    do_reset();
    chk({alt, aout}, 16'hfff7);
    chk({8'h00, r3, r2, r1, r0}, 16'h0095);
    rd_chk(OFF_FUNC_SEL, FUNC_SEL_RST);
    rd_chk(OFF_PIN_DIR, PIN_DIR_RST);
    for (int k = 0; k < 8; k++) begin
      c = k[1:0];
      pull_want <= k[2];
      wr_reg(OFF_FUNC_SEL, {c[0] ? 8'hff : 8'haa, {4{c}}});
      rd_chk(OFF_FUNC_SEL, {c[0] ? 8'hff : 8'haa, {4{c}}});
      chk({alt[7:4], aout[7:4], rsvd}, {{2{c[0] ? 4'hf : 4'h0}}, c == 3 ? 8'h0f : 8'h00});
      chk({alt[3:0], aout[3:0], r3, r2, r1, r0}, {(c == 1 || c == 2) ? 4'hf : 4'h0,
        c == 1 ? 4'hf : (c == 2 ? 4'h2 : 4'h0), {4{c == 3 ? 2'h0 : c}}});
      chk({15'h0, pull}, {15'h0, c == 2 && k[2]});
    end
    mix <= 1'b1;
    wr_reg(OFF_PIN_DIR, 16'hffff);
    wr_reg(4'h4, 16'h0000);
    rd_chk(OFF_PIN_DIR, 16'hffff);
    rd_chk(4'h4, 16'h0000);
    chk(out_en, 16'h7777);
    wr_reg(OFF_PIN_DIR, 16'h00f0);
    rd_chk(OFF_PIN_DIR, 16'h00f0);
    chk(out_en, 16'h0070);
    do_reset();
    rd_chk(OFF_FUNC_SEL, FUNC_SEL_RST);
    rd_chk(OFF_PIN_DIR, PIN_DIR_RST);
    chk(out_en, 16'h0000);
    finish_test();
  end
endmodule // pmx_port_mux_bench
bind pmx_port_mux pmx_chk pmx_chk_i (.*);
